/* File: logic/srr_defines.svh */
// Constants of the status reporting register block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SRR_DEFINES_SVH
`define SRR_DEFINES_SVH

`define SRR_WIDTH        16
`define SRR_MSB          15
`define SRR_NGROUPS      2
`define SRR_ZERO         16'h0000
`define SRR_PTR_PRESET   16'h7fff
`define SRR_NTR_PRESET   16'h0000
`define SRR_EN_PRESET    16'h0000
`define SRR_GRP_OPER     1'b0
`define SRR_GRP_QUES     1'b1

`endif

/* File: logic/srr_pkg.sv */
// Types shared by the status reporting register block.
// Assumes the defines header is on the include path.
`include "srr_defines.svh"

package srr_pkg;

  // Kind of decoded remote command
  typedef enum logic [1:0] {
    SRR_OP_READ   = 2'b00,
    SRR_OP_WRITE  = 2'b01,
    SRR_OP_PRESET = 2'b10,
    SRR_OP_NONE   = 2'b11
  } srr_op_t;

  // Register within one group
  typedef enum logic [2:0] {
    SRR_SEL_COND  = 3'b000,
    SRR_SEL_EN    = 3'b001,
    SRR_SEL_EVENT = 3'b010,
    SRR_SEL_NTR   = 3'b011,
    SRR_SEL_PTR   = 3'b100
  } srr_sel_t;

  // One decoded command from the remote command parser
  typedef struct packed {
    srr_op_t                op;
    logic                   group;
    srr_sel_t               sel;
    logic [`SRR_MSB:0]      data;
  } srr_cmd_t;

  // Answer to one command
  typedef struct packed {
    logic                   err;
    logic [`SRR_MSB:0]      data;
  } srr_resp_t;

endpackage

/* File: logic/srr_sync2.sv */
// Two-flop synchroniser for a bus of independent level signals.
// Assumes each bit is a slow level; no bus coherence is promised.
`include "srr_defines.svh"
module srr_sync2 #(
  parameter int WIDTH = `SRR_WIDTH
) (
  input  wire logic             mclk_in,    // System clock
  input  wire logic             reset_n_in, // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] async_in,   // Levels from outside the domain
  output logic      [WIDTH-1:0] sync_out    // Levels after two flops
);

  logic [WIDTH-1:0] meta_r;

  // First flop feeds only the second
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* File: logic/srr_status_regs.sv */
// Status reporting block: operation and questionable register groups.
// Assumes a command parser on mclk_in hands over one decoded command per
// valid cycle, and condition levels arrive from outside the clock domain.
`include "srr_defines.svh"

// What this block does
// [RULE1] Operation condition readable, read leaves it unchanged
// [RULE2] Questionable condition readable, independent of operation
// [RULE3] Operation enable register written and read back
// [RULE4] Questionable enable register written and read back
// [RULE5] Operation event read returns value, then clears
// [RULE6] Questionable event read returns value, then clears
// [RULE7] Operation falling filter written and read back
// [RULE8] Questionable falling filter written and read back
// [RULE9] Rising filters of both groups written and read
// [RULE10] Preset loads both rising filters with 7fff
// [RULE11] Preset clears falling filters and enables
// [RULE12] Filtered condition edges set sticky event bits
// [RULE13] Summary is OR of enabled event bits
module srr_status_regs
  import srr_pkg::*;
(
  input  wire logic                  mclk_in,        // System clock, 100 MHz
  input  wire logic                  reset_n_in,     // Synchronous reset, active low
  input  wire logic                  cmd_valid_in,   // Command present this cycle
  input  wire srr_cmd_t              cmd_in,         // Decoded remote command
  input  wire logic [`SRR_MSB:0]     oper_cond_in,   // Operation condition levels
  input  wire logic [`SRR_MSB:0]     ques_cond_in,   // Questionable condition levels
  output srr_resp_t                  resp_out,       // Answer to the last command
  output logic                       resp_valid_out, // Answer strobe, one cycle
  output logic                       oper_summary_out, // Operation group summary
  output logic                       ques_summary_out  // Questionable group summary
);

  logic [`SRR_MSB:0] cond_in_w [`SRR_NGROUPS];
  logic [`SRR_MSB:0] cond_r    [`SRR_NGROUPS];
  logic [`SRR_MSB:0] prev_r    [`SRR_NGROUPS];
  logic [`SRR_MSB:0] enable_r  [`SRR_NGROUPS];
  logic [`SRR_MSB:0] event_r   [`SRR_NGROUPS];
  logic [`SRR_MSB:0] event_nxt [`SRR_NGROUPS];
  logic [`SRR_MSB:0] ntr_r     [`SRR_NGROUPS];
  logic [`SRR_MSB:0] ptr_r     [`SRR_NGROUPS];
  logic [`SRR_MSB:0] rd_val    [`SRR_NGROUPS];
  logic              summary_r [`SRR_NGROUPS];
  logic              preset_w;

  // True when the command addresses one register of one group
  function automatic logic cmd_hits(input logic valid, input srr_cmd_t cmd, input srr_op_t op,
                                    input logic grp, input srr_sel_t sel);
    cmd_hits = valid && (cmd.op == op) && (cmd.group == grp) && (cmd.sel == sel);
  endfunction

  // Read mux over the registers of one group
  function automatic logic [`SRR_MSB:0] read_sel(input srr_sel_t sel,
                                                 input logic [`SRR_MSB:0] cond,
                                                 input logic [`SRR_MSB:0] en,
                                                 input logic [`SRR_MSB:0] ev,
                                                 input logic [`SRR_MSB:0] ntr,
                                                 input logic [`SRR_MSB:0] ptr);
    unique case (sel)
      SRR_SEL_COND:  read_sel = cond;
      SRR_SEL_EN:    read_sel = en;
      SRR_SEL_EVENT: read_sel = ev;
      SRR_SEL_NTR:   read_sel = ntr;
      SRR_SEL_PTR:   read_sel = ptr;
      default:       read_sel = `SRR_ZERO;
    endcase
  endfunction

  // Writes to read-only targets, unknown selectors on reads and writes, and NONE are refused
  function automatic logic cmd_error(input srr_cmd_t cmd);
    logic bad;
    bad = 1'b0;
    unique case (cmd.op)
      SRR_OP_READ: begin
        bad = (cmd.sel > SRR_SEL_PTR);
      end
      SRR_OP_WRITE: begin
        bad = (cmd.sel == SRR_SEL_COND) || (cmd.sel == SRR_SEL_EVENT) || (cmd.sel > SRR_SEL_PTR);
      end
      SRR_OP_PRESET: begin
        bad = 1'b0;
      end
      SRR_OP_NONE: begin
        bad = 1'b1;
      end
    endcase
    cmd_error = bad;
  endfunction

  assign cond_in_w[0] = oper_cond_in;
  assign cond_in_w[1] = ques_cond_in;
  assign preset_w     = cmd_valid_in && (cmd_in.op == SRR_OP_PRESET);

  genvar g;
  generate
    for (g = 0; g < `SRR_NGROUPS; g++) begin : grp
      localparam logic GRP = 1'(g);
      logic [`SRR_MSB:0] sync_w;
      logic [`SRR_MSB:0] set_w;
      logic              rd_event_w;

      // Conditions come from another domain, so they are synchronised first
      srr_sync2 #(
        .WIDTH      (`SRR_WIDTH)
      ) u_sync (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .async_in   (cond_in_w[g]),
        .sync_out   (sync_w)
      );

      // Condition register and its previous value for edge detection
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          cond_r[g] <= `SRR_ZERO;
          prev_r[g] <= `SRR_ZERO;
        end else begin
          cond_r[g] <= sync_w;    // see [RULE1] see [RULE2]
          prev_r[g] <= cond_r[g];
        end
      end

      // Enable register, written by the host or cleared by preset
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          enable_r[g] <= `SRR_EN_PRESET;
        end else if (preset_w) begin
          enable_r[g] <= `SRR_EN_PRESET;    // see [RULE11]
        end else if (cmd_hits(cmd_valid_in, cmd_in, SRR_OP_WRITE, GRP, SRR_SEL_EN)) begin
          enable_r[g] <= cmd_in.data;       // see [RULE3] see [RULE4]
        end
      end

      // Falling-edge filter register
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          ntr_r[g] <= `SRR_NTR_PRESET;
        end else if (preset_w) begin
          ntr_r[g] <= `SRR_NTR_PRESET;      // see [RULE11]
        end else if (cmd_hits(cmd_valid_in, cmd_in, SRR_OP_WRITE, GRP, SRR_SEL_NTR)) begin
          ntr_r[g] <= cmd_in.data;          // see [RULE7] see [RULE8]
        end
      end

      // Rising-edge filter register
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          ptr_r[g] <= `SRR_PTR_PRESET;
        end else if (preset_w) begin
          ptr_r[g] <= `SRR_PTR_PRESET;      // see [RULE10]
        end else if (cmd_hits(cmd_valid_in, cmd_in, SRR_OP_WRITE, GRP, SRR_SEL_PTR)) begin
          ptr_r[g] <= cmd_in.data;          // see [RULE9]
        end
      end

      // Filtered edges; a condition high at reset release counts as rising
      assign set_w = (cond_r[g] & ~prev_r[g] & ptr_r[g])
                   | (~cond_r[g] & prev_r[g] & ntr_r[g]);    // see [RULE12]
      assign rd_event_w = cmd_hits(cmd_valid_in, cmd_in, SRR_OP_READ, GRP, SRR_SEL_EVENT);

      // Set beats the read-clear so no edge is lost in the clearing cycle
      always_comb begin
        event_nxt[g] = (rd_event_w ? `SRR_ZERO : event_r[g]) | set_w;    // see [RULE5] see [RULE6]
      end

      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          event_r[g] <= `SRR_ZERO;
        end else begin
          event_r[g] <= event_nxt[g];       // see [RULE12]
        end
      end

      // Summary lags the registers by one cycle, traded for a flop output
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          summary_r[g] <= 1'b0;
        end else begin
          summary_r[g] <= |(event_r[g] & enable_r[g]);    // see [RULE13]
        end
      end

      assign rd_val[g] = read_sel(cmd_in.sel, cond_r[g], enable_r[g], event_r[g], ntr_r[g], ptr_r[g]);
    end
  endgenerate

  // One answer per command; event reads return the value before clearing
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      resp_valid_out <= 1'b0;
      resp_out       <= '0;
    end else begin
      resp_valid_out <= cmd_valid_in;
      if (cmd_valid_in) begin
        resp_out.err  <= cmd_error(cmd_in);
        if ((cmd_in.op == SRR_OP_READ) && !cmd_error(cmd_in)) begin
          resp_out.data <= (cmd_in.group == `SRR_GRP_QUES) ? rd_val[1] : rd_val[0];    // see [RULE5] see [RULE6]
        end else begin
          resp_out.data <= `SRR_ZERO;
        end
      end
    end
  end

  assign oper_summary_out = summary_r[0];
  assign ques_summary_out = summary_r[1];

endmodule

/* File: dv/srr_status_regs_monitor.sv */
// Checker of the status register block, command port side.
// Assumes it sees only the top module's ports; bound after the module.
`include "srr_defines.svh"
module srr_status_regs_monitor
  import srr_pkg::*;
(
  input wire logic              mclk_in,          // Clock
  input wire logic              reset_n_in,       // Reset, active low
  input wire logic              cmd_valid_in,     // Command strobe
  input wire srr_cmd_t          cmd_in,           // Command word
  input wire logic [`SRR_MSB:0] oper_cond_in,     // Operation levels
  input wire logic [`SRR_MSB:0] ques_cond_in,     // Questionable levels
  input wire srr_resp_t         resp_out,         // Answer
  input wire logic              resp_valid_out,   // Answer strobe
  input wire logic              oper_summary_out, // Operation summary
  input wire logic              ques_summary_out  // Questionable summary
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // Decoded command kinds
  wire logic cmd_rd = cmd_valid_in && cmd_in.op == SRR_OP_READ;
  wire logic cmd_pre = cmd_valid_in && cmd_in.op == SRR_OP_PRESET;
  wire logic cmd_wr_ok = cmd_valid_in && cmd_in.op == SRR_OP_WRITE && cmd_in.sel inside {SRR_SEL_EN, SRR_SEL_NTR, SRR_SEL_PTR};
  // Answer timing; a held answer keeps the host from reading a stale word
  AST_ANS: assert property (cmd_valid_in |=> resp_valid_out) else $error("no answer");
  AST_NOANS: assert property (!cmd_valid_in |=> !resp_valid_out) else $error("stray answer");
  AST_HOLD: assert property (!cmd_valid_in |=> $stable(resp_out)) else $error("answer moved");
  AST_WR: assert property (cmd_wr_ok |=> resp_out == '0) else $error("write answer wrong");
  AST_NONE: assert property (cmd_valid_in && cmd_in.op == SRR_OP_NONE |=> resp_out.err) else $error("none taken");
  AST_CONDRO: assert property (cmd_valid_in && cmd_in.op == SRR_OP_WRITE && cmd_in.sel == SRR_SEL_COND
    |=> resp_out == 17'h10000) else $error("condition written");
  // Write then read of the same place returns the written word
  AST_RB: assert property (cmd_wr_ok ##1 cmd_rd && cmd_in.group == $past(cmd_in.group) && cmd_in.sel == $past(cmd_in.sel)
    |=> resp_out == {1'b0, $past(cmd_in.data, 2)}) else $error("read back wrong");
  AST_PRE: assert property (cmd_pre ##1 cmd_rd && cmd_in.sel == SRR_SEL_PTR |=> resp_out == 17'h07fff) else $error("preset ptr");
  AST_PRE0: assert property (cmd_pre ##1 cmd_rd && cmd_in.sel inside {SRR_SEL_EN, SRR_SEL_NTR}
    |=> resp_out == '0) else $error("preset clear");
  // Main scenarios reached
  cover property (cmd_pre ##1 cmd_rd);
  cover property ($rose(oper_summary_out));
  cover property ($rose(ques_summary_out));
endmodule
bind srr_status_regs srr_status_regs_monitor u_srr_status_regs_monitor (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
  .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .oper_cond_in(oper_cond_in), .ques_cond_in(ques_cond_in),
  .resp_out(resp_out), .resp_valid_out(resp_valid_out), .oper_summary_out(oper_summary_out),
  .ques_summary_out(ques_summary_out));

/* File: dv/srr_host_model.sv */
// Remote host model: issues decoded commands and takes the answers.
// Assumes the bench calls its tasks at a falling clock edge.
module srr_host_model
  import srr_pkg::*;
(
  input  wire logic      mclk_in,   // Clock
  input  wire srr_resp_t resp_in,   // Answer from the block
  output logic           valid_out, // Command strobe
  output srr_cmd_t       cmd_out    // Command word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle with a refused code, so a stray strobe does no harm
  initial begin
    valid_out = 1'b0;
    cmd_out = {SRR_OP_NONE, 20'h00000};
  end
  // Held across one taking edge; answer read mid-pulse
  task automatic send(input srr_cmd_t c, output srr_resp_t r);
    valid_out = 1'b1;
    cmd_out = c;
    @(negedge mclk_in);
    r = resp_in;
  endtask
  // Released word is scrambled, not left showing the last command
  task automatic idle();
    valid_out = 1'b0;
    cmd_out = ~cmd_out;
    @(negedge mclk_in);
  endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench of the status register block.
// Assumes the host model drives the command port at falling edges.
module tb;
  import srr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in, reset_n_in, cmd_valid, resp_valid, oper_sum, ques_sum;
  srr_cmd_t    cmd;
  srr_resp_t   resp, r;
  logic [15:0] oper_cond, ques_cond;
  int          n_mismatch, num_checks;
  // Rows: op, group, sel, data, then expected err and data
  localparam int NROW = 15;
  localparam logic [38:0] ROWS [NROW] = '{
    {2'b00,1'b0,3'b001,16'h0000,17'h00000}, {2'b00,1'b1,3'b100,16'h0000,17'h07fff},
    {2'b01,1'b0,3'b001,16'hffff,17'h00000}, {2'b00,1'b0,3'b001,16'h0000,17'h0ffff},
    {2'b01,1'b1,3'b001,16'h00ff,17'h00000}, {2'b00,1'b1,3'b001,16'h0000,17'h000ff},
    {2'b01,1'b0,3'b011,16'h1234,17'h00000}, {2'b00,1'b0,3'b011,16'h0000,17'h01234},
    {2'b01,1'b1,3'b011,16'h0f0f,17'h00000}, {2'b00,1'b1,3'b011,16'h0000,17'h00f0f},
    {2'b01,1'b0,3'b100,16'h0001,17'h00000}, {2'b00,1'b0,3'b100,16'h0000,17'h00001},
    {2'b01,1'b0,3'b000,16'h5555,17'h10000}, {2'b11,1'b0,3'b001,16'h5555,17'h10000},
    {2'b00,1'b1,3'b101,16'h0000,17'h10000}};
  srr_status_regs u_srr_status_regs (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .oper_cond_in(oper_cond), .ques_cond_in(ques_cond), .resp_out(resp),
    .resp_valid_out(resp_valid), .oper_summary_out(oper_sum), .ques_summary_out(ques_sum));
  srr_host_model u_srr_host_model (.mclk_in(mclk_in), .resp_in(resp), .valid_out(cmd_valid), .cmd_out(cmd));
  // Compare and count
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One command and its expected answer
  task automatic cc(input srr_op_t op, input logic g, input srr_sel_t s, input logic [15:0] d, input logic [16:0] e);
    u_srr_host_model.send({op, g, s, d}, r);
    chk(r, e);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // 100 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Watchdog, far beyond the 64 or so cycles of the run
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    reset_n_in = 1'b0;
    oper_cond = 16'h0000;
    ques_cond = 16'h0000;
    repeat (2) @(negedge mclk_in);
    reset_n_in = 1'b1;
    for (int i = 0; i < NROW; i++) begin
      u_srr_host_model.send(ROWS[i][38:17], r);
      chk(r, ROWS[i][16:0]);
    end
    // Preset, then at once read each filter, enable and event
    for (int g = 0; g < 2; g++) for (int s = 1; s < 5; s++) begin
      cc(SRR_OP_PRESET, 1'b0, SRR_SEL_COND, 16'h0000, 17'h00000);
      cc(SRR_OP_READ, g[0], srr_sel_t'(s[2:0]), 16'h0000, (s == 4) ? 17'h07fff : 17'h00000);
    end
    cc(SRR_OP_WRITE, 1'b0, SRR_SEL_EN, 16'h0001, 17'h00000);
    cc(SRR_OP_WRITE, 1'b1, SRR_SEL_EN, 16'h8000, 17'h00000);
    cc(SRR_OP_WRITE, 1'b1, SRR_SEL_NTR, 16'h8000, 17'h00000);
    u_srr_host_model.idle();
    // Rise on bit 0 passes the rising filter; bit 15 is filtered out
    oper_cond = 16'h0001;
    ques_cond = 16'h8000;
    repeat (6) @(negedge mclk_in);
    chk({16'h0000, oper_sum}, 17'h00001);
    chk({16'h0000, ques_sum}, 17'h00000);
    cc(SRR_OP_READ, 1'b1, SRR_SEL_EVENT, 16'h0000, 17'h00000);
    u_srr_host_model.idle();
    ques_cond = 16'h0000;
    repeat (6) @(negedge mclk_in);
    chk({16'h0000, ques_sum}, 17'h00001);
    cc(SRR_OP_READ, 1'b1, SRR_SEL_EVENT, 16'h0000, 17'h08000);
    cc(SRR_OP_READ, 1'b1, SRR_SEL_EVENT, 16'h0000, 17'h00000);
    cc(SRR_OP_READ, 1'b0, SRR_SEL_EVENT, 16'h0000, 17'h00001);
    cc(SRR_OP_READ, 1'b0, SRR_SEL_EVENT, 16'h0000, 17'h00000);
    cc(SRR_OP_READ, 1'b1, SRR_SEL_COND, 16'h0000, 17'h00000);
    cc(SRR_OP_READ, 1'b0, SRR_SEL_COND, 16'h0000, 17'h00001);
    cc(SRR_OP_READ, 1'b0, SRR_SEL_COND, 16'h0000, 17'h00001);
    u_srr_host_model.idle();
    chk({16'h0000, oper_sum | ques_sum}, 17'h00000);
    // Second reset in mid-run clears the held answer, the operation enable and the questionable falling filter
    reset_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk(resp, 17'h00000);
    chk({16'h0000, resp_valid}, 17'h00000);
    reset_n_in = 1'b1;
    cc(SRR_OP_READ, 1'b0, SRR_SEL_EN, 16'h0000, 17'h00000);
    cc(SRR_OP_READ, 1'b1, SRR_SEL_NTR, 16'h0000, 17'h00000);
    u_srr_host_model.idle();
    close_out();
  end
endmodule
